// ==== design/fan_pwm_pkg.sv ====
package fan_pwm_pkg;

    // Register offsets on the register port
    localparam logic [7:0] ENHANCED_CONFIG_ADDR = 8'h45;
    localparam logic [7:0] PWM_TACH_CONFIG_ADDR = 8'h4a;
    localparam logic [7:0] DUTY_VALUE_ADDR      = 8'h4c;
    localparam logic [7:0] PERIOD_DIVIDE_ADDR   = 8'h4d;

    // Reset values
    localparam logic [7:0] ENHANCED_CONFIG_RST  = 8'h00;
    localparam logic [7:0] PWM_TACH_CONFIG_RST  = 8'h00;
    localparam logic [7:0] DUTY_VALUE_RST       = 8'h00;
    localparam logic [7:0] PERIOD_DIVIDE_RST    = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA       = 8'h00;

    // Field positions
    localparam int HIGH_RES_SELECT_BIT   = 4;
    localparam int SLOW_CLOCK_SELECT_BIT = 3;
    localparam int PERIOD_FIELD_MSB      = 4;
    localparam int DUTY_NORMAL_MSB       = 5;

    // Mode codes and scale values
    localparam logic [4:0] HIRES_PERIOD_SETTING = 5'h08;
    localparam logic [7:0] HIRES_FULL_SCALE     = 8'hff;
    localparam logic [7:0] MIN_FULL_SCALE       = 8'h02;

    // Timing: clock and source rates in Hz
    localparam int MCLK_HZ      = 200_000_000;
    localparam int FAST_TICK_HZ = 360_000;
    localparam int SLOW_TICK_HZ = 1_400;
    localparam int HIRES_PWM_HZ = 22_500;
    localparam int HIRES_STEPS  = 255;

    // Cycle counts derived from the rates, rounded down
    localparam int FAST_DIV_CYC  = MCLK_HZ / FAST_TICK_HZ;
    localparam int SLOW_DIV_CYC  = MCLK_HZ / SLOW_TICK_HZ;
    localparam int HIRES_DIV_CYC = MCLK_HZ / (HIRES_PWM_HZ * HIRES_STEPS);

    // Width of the tick divider counter
    localparam int DIV_W = 18;

endpackage : fan_pwm_pkg

// ==== design/tick_divider.sv ====
`timescale 1ns/100ps
`default_nettype none

module tick_divider
    import fan_pwm_pkg::*;
#(
    parameter int W = DIV_W
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Divide ratio in mclk cycles
    input  wire logic [W-1:0] divisor,
    // One-cycle tick
    output logic              tick
);

    logic [W-1:0] cnt_ff;       // Cycle counter
    logic [W-1:0] nxt_cnt;
    logic         tick_ff;      // Registered tick
    logic         nxt_tick;

    // Wrap also on a counter past a newly shrunk divisor
    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + 1'b1;
        if (cnt_ff >= divisor - 1'b1) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : tick_divider

`default_nettype wire

// ==== design/fan_pwm_duty_generator.sv ====
// How it works
// - High-res needs select set, fast clock, setting eight
// - High-res uses full byte, FF full duty
// - High-res only from fast source at 22.5 kHz
// - Normal full-scale count is twice setting
// - Frequency is tick rate over full scale
// - High time is duty over full scale
// - Duty steps one count of full scale
// - Setting zero behaves like setting one
`timescale 1ns/100ps
`default_nettype none

module fan_pwm_duty_generator
    import fan_pwm_pkg::*;
#(
    parameter int FAST_DIV  = FAST_DIV_CYC,
    parameter int SLOW_DIV  = SLOW_DIV_CYC,
    parameter int HIRES_DIV = HIRES_DIV_CYC
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Open-drain fan drive pin
    output logic            pwm_o,
    output logic            pwm_oe_n,
    // Fan-on state, for observation
    output logic            fan_on
);

    // Software registers
    logic [7:0] enhanced_config_ff;
    logic [7:0] pwm_tach_config_ff;
    logic [7:0] duty_value_ff;
    logic [7:0] period_divide_ff;
    logic [7:0] rdata_ff;           // Read data, held until next read
    logic [7:0] nxt_enhanced_config;
    logic [7:0] nxt_pwm_tach_config;
    logic [7:0] nxt_duty_value;
    logic [7:0] nxt_period_divide;
    logic [7:0] nxt_rdata;

    // Derived controls
    logic             high_res_select;   // Request for high-res
    logic             slow_clock_select; // Slow source chosen
    logic             hires;             // High-res mode active
    logic [4:0]       period_setting;    // Frequency setting
    logic [7:0]       full_scale;        // Counts per period
    logic [7:0]       duty_eff;          // Duty in use
    logic [DIV_W-1:0] divisor;           // Tick divide ratio
    logic             tick;              // Internal counting tick

    // Period counter and output
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       fan_on_ff;
    logic       nxt_fan_on;

    // Register writes and reads
    always_comb begin
        nxt_enhanced_config = enhanced_config_ff;
        nxt_pwm_tach_config = pwm_tach_config_ff;
        nxt_duty_value      = duty_value_ff;
        nxt_period_divide   = period_divide_ff;
        nxt_rdata           = rdata_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                ENHANCED_CONFIG_ADDR: nxt_enhanced_config = reg_wdata;
                PWM_TACH_CONFIG_ADDR: nxt_pwm_tach_config = reg_wdata;
                DUTY_VALUE_ADDR:      nxt_duty_value      = reg_wdata;
                PERIOD_DIVIDE_ADDR:   nxt_period_divide   = reg_wdata;
                default: ;          // Writes elsewhere are dropped
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ENHANCED_CONFIG_ADDR: nxt_rdata = enhanced_config_ff;
                PWM_TACH_CONFIG_ADDR: nxt_rdata = pwm_tach_config_ff;
                DUTY_VALUE_ADDR:      nxt_rdata = duty_value_ff;
                PERIOD_DIVIDE_ADDR:   nxt_rdata = period_divide_ff;
                default:              nxt_rdata = UNMAPPED_RDATA;
            endcase
        end
    end

    // Register stage for the register file
    always_ff @(posedge mclk) begin
        if (rst) begin
            enhanced_config_ff <= ENHANCED_CONFIG_RST;
            pwm_tach_config_ff <= PWM_TACH_CONFIG_RST;
            duty_value_ff      <= DUTY_VALUE_RST;
            period_divide_ff   <= PERIOD_DIVIDE_RST;
            rdata_ff           <= UNMAPPED_RDATA;
        end else begin
            enhanced_config_ff <= nxt_enhanced_config;
            pwm_tach_config_ff <= nxt_pwm_tach_config;
            duty_value_ff      <= nxt_duty_value;
            period_divide_ff   <= nxt_period_divide;
            rdata_ff           <= nxt_rdata;
        end
    end

    // Mode decode and scale selection
    always_comb begin
        high_res_select   = enhanced_config_ff[HIGH_RES_SELECT_BIT];
        slow_clock_select = pwm_tach_config_ff[SLOW_CLOCK_SELECT_BIT];
        period_setting    = period_divide_ff[PERIOD_FIELD_MSB:0];
        // All three conditions together
        hires = high_res_select && !slow_clock_select
                && (period_setting == HIRES_PERIOD_SETTING);
        if (hires) begin
            // Full byte of duty, FF means full on
            full_scale = HIRES_FULL_SCALE;
            duty_eff   = duty_value_ff;
            divisor    = DIV_W'(HIRES_DIV);
        end else begin
            // Twice the setting, upper duty bits unused
            full_scale = {2'b00, period_setting, 1'b0};
            duty_eff   = {2'b00, duty_value_ff[DUTY_NORMAL_MSB:0]};
            divisor    = slow_clock_select ? DIV_W'(SLOW_DIV)
                                           : DIV_W'(FAST_DIV);
            // Setting zero maps onto setting one
            if (period_setting == 5'h00) begin
                full_scale = MIN_FULL_SCALE;
            end
        end
    end

    // Tick source; a mode change may stretch one period
    tick_divider #(
        .W       (DIV_W)
    ) u_tick (
        .mclk    (mclk),
        .rst     (rst),
        .divisor (divisor),
        .tick    (tick)
    );

    // Period counter and output compare
    always_comb begin
        nxt_cnt = cnt_ff;
        if (tick) begin
            // Wrap at full scale; also catches a shrunk scale
            if (cnt_ff >= full_scale - 8'h01) begin
                nxt_cnt = 8'h00;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
        // High for duty counts of the period
        nxt_fan_on = (cnt_ff < duty_eff)
                     || (duty_eff >= full_scale);
    end

    // Register stage for counter and pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff    <= 8'h00;
            fan_on_ff <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            fan_on_ff <= nxt_fan_on;
        end
    end

    // Open drain: pulls low while the fan is off, released when on
    assign pwm_o     = 1'b0;
    assign pwm_oe_n  = fan_on_ff;
    assign fan_on    = fan_on_ff;
    assign reg_rdata = rdata_ff;

    // Checks; mode is judged from the raw register bits, both ways
    a_hires_enable: assert property (
        @(posedge mclk) disable iff (rst)
        hires == (enhanced_config_ff[4] && !pwm_tach_config_ff[3]
                  && period_divide_ff[4:0] == 5'h08))
        else $error("high-res state disagrees with the three settings");
    a_hires_fullbyte: assert property (
        @(posedge mclk) disable iff (rst)
        hires |-> full_scale == 8'hff && duty_eff == duty_value_ff)
        else $error("high-res not using full byte");
    a_hires_fast: assert property (
        @(posedge mclk) disable iff (rst)
        slow_clock_select |-> !hires && divisor == DIV_W'(SLOW_DIV))
        else $error("high-res on slow source");
    a_normal_scale: assert property (
        @(posedge mclk) disable iff (rst)
        !hires && period_setting != 5'h00
        |-> full_scale == 8'(2 * period_setting))
        else $error("normal full scale not twice setting");
    a_period_wrap: assert property (
        @(posedge mclk) disable iff (rst)
        tick && cnt_ff == full_scale - 8'h01 |=> cnt_ff == 8'h00)
        else $error("counter did not wrap at full scale");
    a_duty_high: assert property (
        @(posedge mclk) disable iff (rst)
        cnt_ff < duty_eff |=> fan_on_ff && pwm_oe_n)
        else $error("output not on during duty counts");
    a_duty_low: assert property (
        @(posedge mclk) disable iff (rst)
        cnt_ff >= duty_eff && duty_eff < full_scale |=> !fan_on_ff)
        else $error("output on outside duty counts");
    a_step_count: assert property (
        @(posedge mclk) disable iff (rst)
        tick && cnt_ff < full_scale - 8'h01
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not step by one");
    a_zero_setting: assert property (
        @(posedge mclk) disable iff (rst)
        !hires && period_setting == 5'h00 |-> full_scale == 8'h02)
        else $error("setting zero not mapped to one");
    // Judged one edge on, so a freshly raised duty is not held against it
    a_full_on: assert property (
        @(posedge mclk) disable iff (rst)
        duty_eff >= full_scale |=> fan_on_ff && pwm_oe_n)
        else $error("output dropped at full duty");

    c_hires_mode: cover property (@(posedge mclk) disable iff (rst)
        hires && tick && cnt_ff == 8'hfe);
    c_slow_source: cover property (@(posedge mclk) disable iff (rst)
        slow_clock_select && tick);
    c_normal_pulse: cover property (@(posedge mclk) disable iff (rst)
        !hires && fan_on_ff ##1 !fan_on_ff);
    c_full_on: cover property (@(posedge mclk) disable iff (rst)
        duty_eff >= full_scale && fan_on_ff);

endmodule : fan_pwm_duty_generator

`default_nettype wire

// ==== verification/fan_stage.sv ====
`timescale 1ns/100ps
`default_nettype none

module fan_stage (
    // Drive from the block
    input  wire logic pwm_o,
    input  wire logic pwm_oe_n,
    // Pin level seen by the fan
    output logic      fan_pin
);
    // Pull-up wins once the block lets go, so a released pin reads high
    assign fan_pin = pwm_oe_n ? 1'b1 : pwm_o;
endmodule : fan_stage

`default_nettype wire

// ==== verification/test_fan_pwm_duty_generator.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_fan_pwm_duty_generator
    import fan_pwm_pkg::*;
();
    // Small dividers keep each period short
    localparam int FD = 4;
    localparam int SD = 8;
    localparam int HD = 2;

    // One setup: enh, cfg, divide, duty, window, expected high cycles
    typedef struct packed {
        logic [7:0]  enh;
        logic [7:0]  cfg;
        logic [7:0]  div;
        logic [7:0]  dty;
        logic [15:0] win;
        logic [15:0] hi;
    } pwm_case_t;

    logic        mclk;          // Bench clock
    logic        rst;           // Synchronous reset
    logic [7:0]  reg_addr;      // Register offset
    logic [7:0]  reg_wdata;     // Write data
    logic        reg_wr;        // Write strobe
    logic        reg_rd;        // Read strobe
    logic [7:0]  reg_rdata;     // Read data
    logic        pwm_o;         // Pin data
    logic        pwm_oe_n;      // Pin enable
    logic        fan_on;        // Fan-on state
    logic        fan_pin;       // Resolved pin level
    int          failures;      // Mismatch count
    int          total_checks;  // Comparison count
    pwm_case_t   cs [10];       // Setup table
    logic [7:0]  addrs [4];     // Mapped offsets

    fan_pwm_duty_generator #(.FAST_DIV(FD), .SLOW_DIV(SD), .HIRES_DIV(HD))
    dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_o(pwm_o), .pwm_oe_n(pwm_oe_n),
        .fan_on(fan_on));

    fan_stage fan (.pwm_o(pwm_o), .pwm_oe_n(pwm_oe_n), .fan_pin(fan_pin));

    // Free-running clock
    always #2.5 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr

    // One read, data settled by the next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // Program, let one window pass, then count high cycles over whole periods
    task automatic run(input pwm_case_t c);
        logic [15:0] n;         // High cycles seen on the pin
        logic [15:0] m;         // High cycles seen on the fan-on state
        wr(ENHANCED_CONFIG_ADDR, c.enh);
        wr(PWM_TACH_CONFIG_ADDR, c.cfg);
        wr(PERIOD_DIVIDE_ADDR, c.div);
        wr(DUTY_VALUE_ADDR, c.dty);
        repeat (c.win) @(negedge mclk);
        n = 16'h0000;
        m = 16'h0000;
        repeat (c.win) begin
            @(negedge mclk);
            n = n + {15'h0000, fan_pin};
            m = m + {15'h0000, fan_on};
        end
        check(n, c.hi);
        check(m, c.hi);
        check({15'h0000, pwm_o}, 16'h0000);
    endtask : run

    // Verdict, the single exit of the run
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #100_000;
        failures++;
        end_of_test();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        failures = 0;
        total_checks = 0;
        addrs = '{ENHANCED_CONFIG_ADDR, PWM_TACH_CONFIG_ADDR,
                  DUTY_VALUE_ADDR, PERIOD_DIVIDE_ADDR};
        cs[0] = '{8'h00, 8'h00, 8'h02, 8'h01, 16'd64, 16'd16};
        cs[1] = '{8'h00, 8'h00, 8'h00, 8'h01, 16'd64, 16'd32};
        cs[2] = '{8'h00, 8'h00, 8'h1f, 8'h2f, 16'd248, 16'd188};
        cs[3] = '{8'h00, 8'h00, 8'h02, 8'h04, 16'd64, 16'd64};
        cs[4] = '{8'h10, 8'h00, 8'h08, 8'hbf, 16'd510, 16'd382};
        cs[5] = '{8'h10, 8'h00, 8'h08, 8'hff, 16'd510, 16'd510};
        cs[6] = '{8'h10, 8'h08, 8'h08, 8'h0c, 16'd128, 16'd96};
        cs[7] = '{8'h00, 8'h00, 8'h08, 8'h0c, 16'd64, 16'd48};
        cs[8] = '{8'h10, 8'h00, 8'h07, 8'h0c, 16'd56, 16'd48};
        cs[9] = '{8'h00, 8'h00, 8'h02, 8'h41, 16'd64, 16'd16};
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        // Pin pulled low and fan off straight out of reset
        check({15'h0000, fan_on}, 16'h0000);
        check({15'h0000, pwm_oe_n}, 16'h0000);
        // Reset values, readback, and an unmapped offset
        for (int i = 0; i < 4; i++) rd(addrs[i], 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(addrs[i], 8'ha5 ^ 8'(i));
            rd(addrs[i], 8'ha5 ^ 8'(i));
        end
        wr(8'h46, 8'h5a);
        rd(8'h46, UNMAPPED_RDATA);
        $display("test registers done");
        // Duty and period over every mode setup
        for (int i = 0; i < 10; i++) begin
            run(cs[i]);
            $display("test pwm case %0d done", i);
        end
        // Reset in mid-run clears the registers and stops the fan
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check({15'h0000, fan_on}, 16'h0000);
        check({15'h0000, pwm_oe_n}, 16'h0000);
        for (int i = 0; i < 4; i++) rd(addrs[i], 8'h00);
        $display("test reset done");
        end_of_test();
    end
endmodule : test_fan_pwm_duty_generator

`default_nettype wire
